// [common/instr_exec_defines.svh]
`ifndef INSTR_EXEC_DEFINES_SVH
`define INSTR_EXEC_DEFINES_SVH

// Opcode patterns (upper bits of the instruction word; the whole word for pop and push)
`define OPC_LOAD_BANK     8'h01
`define OPC_LOAD_LIT_W    8'h0E
`define OPC_MULT_LIT      8'h0D
`define OPC_MULT_FILE     7'h01
`define OPC_STORE_W       7'h37
`define OPC_NEGATE        7'h36
`define OPC_COPY_FIRST    4'hC
`define OPC_COPY_SECOND   4'hF
`define OPC_POP           16'h0006
`define OPC_PUSH          16'h0005

// Field positions
`define FLD_ACCESS        8
`define FLD_FILE_MSB      7
`define FLD_ADDR12_MSB    11

// Data space
`define BANK_ACCESS       4'h0
`define ACCESS_SPLIT      8'h80
`define ACCESS_HIGH_BANK  4'hF

// Flag positions in the status byte
`define FLAG_C            0
`define FLAG_DC           1
`define FLAG_Z            2
`define FLAG_OV           3
`define FLAG_N            4

// Reset values and PC step
`define RST_BYTE          8'h00
`define RST_PC            21'h000000
`define PC_STEP           21'h000002

`endif

// [common/instr_exec_pkg.sv]
package instr_exec_pkg;

    // Instruction cycle phase, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_t;

    // Decoded operation
    typedef enum logic [3:0] {
        OP_NONE,
        OP_LOAD_BANK,
        OP_LOAD_LIT_W,
        OP_STORE_W,
        OP_MULT_LIT,
        OP_MULT_FILE,
        OP_NEGATE,
        OP_COPY,
        OP_POP,
        OP_PUSH
    } op_t;

endpackage : instr_exec_pkg

// [rtl/move_multiply_stack_instr_exec.sv]
`timescale 1ns/1ps
`include "instr_exec_defines.svh"
// What this block does
// - Two-word copy moves one byte between any 12-bit addresses, flags untouched.
// - Two-word copy takes two program words and two instruction cycles.
// - Copy reads source in first cycle Q2, writes destination in second cycle Q4.
// - Load-bank-literal writes the literal into the bank select register, flags kept.
// - Load-literal-to-working places the literal in working register, flags kept.
// - Store-working writes working register into the addressed file, flags kept.
// - Single-word file instructions reach all 256 bytes of the selected bank.
// - Access bit zero uses bank 0 below 0x80 and bank 15 from 0x80; one uses the bank select register.
// - Multiply-literal puts unsigned working times literal into product pair.
// - Multiply-file puts unsigned working times file into product pair, operands kept.
// - Both multiplies leave every flag unaltered and take one cycle.
// - Negate replaces file with two's complement, updating N, OV, C, DC, Z.
// - Pop discards the return-stack top; the entry below becomes top.
// - Push places PC plus two on the top and shifts old top deeper.
// - Software writes to the return-stack top bytes are honoured.
module move_multiply_stack_instr_exec (
    input  wire logic        clock,          // 10 MHz core clock
    input  wire logic        resetn,         // Synchronous reset, active low
    input  wire logic        clock_en,       // Freezes all state when low
    input  wire logic        instr_valid,    // Instruction word present at Q1
    input  wire logic [15:0] instr_word,     // Fetched program word
    input  wire logic [20:0] prog_counter,   // Address of current instruction
    input  wire logic [7:0]  mem_rdata,      // Data space read data
    input  wire logic        tos_wr_upper,   // Software write of stack top upper byte
    input  wire logic        tos_wr_high,    // Software write of stack top high byte
    input  wire logic        tos_wr_low,     // Software write of stack top low byte
    input  wire logic [7:0]  tos_wdata,      // Data for stack top byte write
    output logic      [3:0]  phase,          // Current Q phase, one-hot
    output logic             instr_ready,    // High in Q1 when a new word is taken
    output logic      [11:0] mem_addr,       // Data space address
    output logic             mem_rd,         // Read strobe, Q2
    output logic             mem_wr,         // Write strobe, Q4
    output logic      [7:0]  mem_wdata,      // Data space write data
    output logic      [7:0]  working_reg,    // Working register
    output logic      [7:0]  bank_select_reg, // Bank select register
    output logic      [7:0]  product_high_byte, // Product high byte
    output logic      [7:0]  product_low_byte,  // Product low byte
    output logic      [7:0]  status_flags,   // Status byte
    output logic      [20:0] return_stack_top, // Current stack top
    output logic      [20:0] return_stack_next // One level down
);

    localparam int DEPTH = 31;

    instr_exec_pkg::phase_t phase_q, phase_d;
    instr_exec_pkg::op_t    op_q, op_d;
    logic [15:0] word_q, word_d;
    logic        second_q, second_d;      // Copy is in its second cycle
    logic [11:0] addr_q, addr_d;
    logic [7:0]  data_q, data_d;
    logic [7:0]  w_q, w_d, bsr_q, bsr_d, ph_q, ph_d, pl_q, pl_d, st_q, st_d;
    logic [20:0] stk_q [DEPTH];
    logic [20:0] stk_d [DEPTH];
    logic [20:0] pc_q, pc_d;
    logic [15:0] product;
    logic [8:0]  neg_sum;
    logic [7:0]  neg_res;
    logic [11:0] file_addr;

    function automatic instr_exec_pkg::op_t decode(input logic [15:0] w);
        if (w == `OPC_POP)
            return instr_exec_pkg::OP_POP;
        if (w == `OPC_PUSH)
            return instr_exec_pkg::OP_PUSH;
        if (w[15:8] == `OPC_LOAD_BANK)
            return instr_exec_pkg::OP_LOAD_BANK;
        if (w[15:8] == `OPC_LOAD_LIT_W)
            return instr_exec_pkg::OP_LOAD_LIT_W;
        if (w[15:8] == `OPC_MULT_LIT)
            return instr_exec_pkg::OP_MULT_LIT;
        if (w[15:9] == `OPC_MULT_FILE)
            return instr_exec_pkg::OP_MULT_FILE;
        if (w[15:9] == `OPC_STORE_W)
            return instr_exec_pkg::OP_STORE_W;
        if (w[15:9] == `OPC_NEGATE)
            return instr_exec_pkg::OP_NEGATE;
        if (w[15:12] == `OPC_COPY_FIRST)
            return instr_exec_pkg::OP_COPY;
        return instr_exec_pkg::OP_NONE;
    endfunction : decode

    // Bank selection for 8-bit file field
    always_comb
    begin
        if (word_q[`FLD_ACCESS])
            file_addr = {bsr_q[3:0], word_q[`FLD_FILE_MSB:0]};
        else if (word_q[`FLD_FILE_MSB:0] < `ACCESS_SPLIT)
            file_addr = {`BANK_ACCESS, word_q[`FLD_FILE_MSB:0]};
        else
            file_addr = {`ACCESS_HIGH_BANK, word_q[`FLD_FILE_MSB:0]};
    end

    assign product = 16'(w_q * data_q);     // Unsigned 8x8
    assign neg_res = 8'(~data_q + 8'h01);
    assign neg_sum = {1'b0, ~data_q} + 9'h001;

    always_comb
    begin
        phase_d  = phase_q;
        op_d     = op_q;
        word_d   = word_q;
        second_d = second_q;
        addr_d   = addr_q;
        data_d   = data_q;
        w_d      = w_q;
        bsr_d    = bsr_q;
        ph_d     = ph_q;
        pl_d     = pl_q;
        st_d     = st_q;
        pc_d     = pc_q;
        stk_d    = stk_q;
        case (phase_q)
            instr_exec_pkg::PH_Q1:
            begin
                phase_d = instr_exec_pkg::PH_Q2;
                if (second_q)
                begin
                    addr_d = instr_word[`FLD_ADDR12_MSB:0];
                end
                else if (instr_valid)
                begin
                    word_d = instr_word;
                    op_d   = decode(instr_word);
                    pc_d   = prog_counter;
                end
                else
                    op_d = instr_exec_pkg::OP_NONE;
            end
            instr_exec_pkg::PH_Q2:
            begin
                phase_d = instr_exec_pkg::PH_Q3;
                if (op_q == instr_exec_pkg::OP_COPY)
                begin
                    // Second cycle must keep the byte read in the first
                    if (!second_q)
                        data_d = mem_rdata;
                end
                else if (op_q inside {instr_exec_pkg::OP_MULT_FILE, instr_exec_pkg::OP_NEGATE})
                    data_d = mem_rdata;
                else
                    data_d = word_q[7:0];
                if (op_q == instr_exec_pkg::OP_POP)
                begin
                    for (int i = 0; i < DEPTH - 1; i++)
                        stk_d[i] = stk_q[i + 1];
                    stk_d[DEPTH - 1] = `RST_PC;
                end
                if (op_q == instr_exec_pkg::OP_PUSH)
                begin
                    for (int i = 1; i < DEPTH; i++)
                        stk_d[i] = stk_q[i - 1];
                    stk_d[0] = 21'(pc_q + `PC_STEP);
                end
            end
            instr_exec_pkg::PH_Q3:
            begin
                phase_d = instr_exec_pkg::PH_Q4;
            end
            default:
            begin
                phase_d = instr_exec_pkg::PH_Q1;
                case (op_q)
                    instr_exec_pkg::OP_LOAD_BANK:  bsr_d = word_q[7:0];
                    instr_exec_pkg::OP_LOAD_LIT_W: w_d = word_q[7:0];
                    instr_exec_pkg::OP_MULT_LIT,
                    instr_exec_pkg::OP_MULT_FILE:
                    begin
                        ph_d = product[15:8];
                        pl_d = product[7:0];
                    end
                    instr_exec_pkg::OP_NEGATE:
                    begin
                        st_d[`FLAG_N]  = neg_res[7];
                        st_d[`FLAG_Z]  = (neg_res == `RST_BYTE);
                        st_d[`FLAG_C]  = neg_sum[8];
                        st_d[`FLAG_DC] = (({1'b0, ~data_q[3:0]} + 5'h01) > 5'h0F);
                        st_d[`FLAG_OV] = (data_q == 8'h80);
                    end
                    default:
                    begin
                    end
                endcase
                if (op_q == instr_exec_pkg::OP_COPY)
                    second_d = !second_q;
            end
        endcase
        // Software writes land after any push/pop of the same cycle
        if (tos_wr_upper)
            stk_d[0][20:16] = tos_wdata[4:0];
        if (tos_wr_high)
            stk_d[0][15:8] = tos_wdata;
        if (tos_wr_low)
            stk_d[0][7:0] = tos_wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            phase_q  <= instr_exec_pkg::PH_Q1;
            op_q     <= instr_exec_pkg::OP_NONE;
            word_q   <= 16'h0000;
            second_q <= 1'b0;
            addr_q   <= 12'h000;
            data_q   <= `RST_BYTE;
            w_q      <= `RST_BYTE;
            bsr_q    <= `RST_BYTE;
            ph_q     <= `RST_BYTE;
            pl_q     <= `RST_BYTE;
            st_q     <= `RST_BYTE;
            pc_q     <= `RST_PC;
            for (int i = 0; i < DEPTH; i++)
                stk_q[i] <= `RST_PC;
        end
        else if (clock_en)
        begin
            phase_q  <= phase_d;
            op_q     <= op_d;
            word_q   <= word_d;
            second_q <= second_d;
            addr_q   <= addr_d;
            data_q   <= data_d;
            w_q      <= w_d;
            bsr_q    <= bsr_d;
            ph_q     <= ph_d;
            pl_q     <= pl_d;
            st_q     <= st_d;
            pc_q     <= pc_d;
            stk_q    <= stk_d;
        end
    end

    // Memory strobes, driven by phase and op
    always_comb
    begin
        mem_rd    = 1'b0;
        mem_wr    = 1'b0;
        mem_wdata = w_q;
        mem_addr  = file_addr;
        if (op_q == instr_exec_pkg::OP_COPY)
        begin
            mem_addr  = second_q ? addr_q : word_q[`FLD_ADDR12_MSB:0];
            mem_wdata = data_q;
            mem_rd    = !second_q && phase_q == instr_exec_pkg::PH_Q2;
            mem_wr    = second_q && phase_q == instr_exec_pkg::PH_Q4;
        end
        else if (op_q inside {instr_exec_pkg::OP_MULT_FILE, instr_exec_pkg::OP_NEGATE})
        begin
            mem_rd    = phase_q == instr_exec_pkg::PH_Q2;
            mem_wr    = op_q == instr_exec_pkg::OP_NEGATE && phase_q == instr_exec_pkg::PH_Q4;
            mem_wdata = neg_res;
        end
        else if (op_q == instr_exec_pkg::OP_STORE_W)
            mem_wr = phase_q == instr_exec_pkg::PH_Q4;
    end

    assign phase             = phase_q;
    assign instr_ready       = phase_q == instr_exec_pkg::PH_Q1 && !second_q;
    assign working_reg       = w_q;
    assign bank_select_reg   = bsr_q;
    assign product_high_byte = ph_q;
    assign product_low_byte  = pl_q;
    assign status_flags      = st_q;
    assign return_stack_top  = stk_q[0];
    assign return_stack_next = stk_q[1];

    AST_COPY_WRITE_TIMING: assert property (@(posedge clock) disable iff (!resetn)
        (clock_en && mem_rd && op_q == instr_exec_pkg::OP_COPY) ##1 clock_en[*5] |=> mem_wr)
        else $error("copy write not in second cycle Q4");
    AST_COPY_DATA: assert property (@(posedge clock) disable iff (!resetn)
        (clock_en && mem_rd && op_q == instr_exec_pkg::OP_COPY) ##1 clock_en[*5]
        |=> mem_wdata == $past(mem_rdata, 6))
        else $error("copy data mismatch");
    AST_STORE_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (phase_q == instr_exec_pkg::PH_Q4 && op_q == instr_exec_pkg::OP_STORE_W)
        |-> mem_wr && mem_wdata == w_q)
        else $error("store write missing");
    AST_MULT_FLAGS: assert property (@(posedge clock) disable iff (!resetn)
        (op_q inside {instr_exec_pkg::OP_MULT_LIT, instr_exec_pkg::OP_MULT_FILE}) |=> $stable(st_q))
        else $error("multiply changed flags");
    AST_MULT_RESULT: assert property (@(posedge clock) disable iff (!resetn)
        (clock_en && phase_q == instr_exec_pkg::PH_Q4 && op_q == instr_exec_pkg::OP_MULT_LIT)
        |=> {ph_q, pl_q} == 16'($past(w_q) * $past(word_q[7:0])))
        else $error("multiply literal result wrong");
    AST_PUSH_VALUE: assert property (@(posedge clock) disable iff (!resetn)
        (clock_en && phase_q == instr_exec_pkg::PH_Q2 && op_q == instr_exec_pkg::OP_PUSH
         && !tos_wr_upper && !tos_wr_high && !tos_wr_low)
        |=> stk_q[0] == 21'($past(pc_q) + `PC_STEP) && stk_q[1] == $past(stk_q[0]))
        else $error("push value wrong");
    AST_POP_SHIFT: assert property (@(posedge clock) disable iff (!resetn)
        (clock_en && phase_q == instr_exec_pkg::PH_Q2 && op_q == instr_exec_pkg::OP_POP
         && !tos_wr_upper && !tos_wr_high && !tos_wr_low) |=> stk_q[0] == $past(stk_q[1]))
        else $error("pop did not shift");
    AST_BANK_LOAD: assert property (@(posedge clock) disable iff (!resetn)
        (clock_en && phase_q == instr_exec_pkg::PH_Q4 && op_q == instr_exec_pkg::OP_LOAD_BANK)
        |=> bsr_q == $past(word_q[7:0]))
        else $error("bank load wrong");
    AST_NEG_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (mem_wr && op_q == instr_exec_pkg::OP_NEGATE) |-> mem_wdata == 8'(8'h00 - data_q))
        else $error("negate result wrong");

endmodule : move_multiply_stack_instr_exec

// [verification/move_multiply_stack_instr_exec_tb_top.sv]
`timescale 1ns/1ps
module move_multiply_stack_instr_exec_tb_top;
    logic        clock        = 1'b0;
    logic        resetn       = 1'b0;
    logic        clock_en     = 1'b1;
    logic        instr_valid  = 1'b0;
    logic [15:0] instr_word   = 16'h0000;
    logic [20:0] prog_counter = 21'h000000;
    logic [7:0]  mem_rdata    = 8'h00;
    logic        tos_wr_upper = 1'b0;
    logic        tos_wr_high  = 1'b0;
    logic        tos_wr_low   = 1'b0;
    logic [7:0]  tos_wdata    = 8'h00;
    logic [3:0]  phase;
    logic        instr_ready;
    logic [11:0] mem_addr;
    logic        mem_rd;
    logic        mem_wr;
    logic [7:0]  mem_wdata;
    logic [7:0]  working_reg;
    logic [7:0]  bank_select_reg;
    logic [7:0]  product_high_byte;
    logic [7:0]  product_low_byte;
    logic [7:0]  status_flags;
    logic [20:0] return_stack_top;
    logic [20:0] return_stack_next;
    int          fails      = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          rd_n;
    int          wr_n;
    logic [11:0] rd_a;
    logic [11:0] wr_a;
    logic [7:0]  wr_v;
    logic        rdy;

    move_multiply_stack_instr_exec move_multiply_stack_instr_exec_i (
        .clock(clock), .resetn(resetn), .clock_en(clock_en), .instr_valid(instr_valid),
        .instr_word(instr_word), .prog_counter(prog_counter), .mem_rdata(mem_rdata),
        .tos_wr_upper(tos_wr_upper), .tos_wr_high(tos_wr_high), .tos_wr_low(tos_wr_low),
        .tos_wdata(tos_wdata), .phase(phase), .instr_ready(instr_ready), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .working_reg(working_reg),
        .bank_select_reg(bank_select_reg), .product_high_byte(product_high_byte),
        .product_low_byte(product_low_byte), .status_flags(status_flags),
        .return_stack_top(return_stack_top), .return_stack_next(return_stack_next)
    );

    always #50 clock = ~clock;

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    // Bound the run well above the two hundred or so cycles the scenarios need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
            fails++;
        end
    endtask : chk

    // Issues n words starting at the next Q1; strobes sampled in Q2 and Q4
    task automatic run(input logic [15:0] w1, input logic [15:0] w2, input int n,
                       input logic [7:0] rd, input logic [20:0] pc);
        int k;
        rd_n = 0;
        wr_n = 0;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (phase !== instr_exec_pkg::PH_Q4 && k < 20);
        for (int c = 0; c < n; c++)
        begin
            instr_word <= (c == 0) ? w1 : w2;
            instr_valid <= (c == 0);
            prog_counter <= pc;
            mem_rdata <= rd;
            #1;
            rdy = instr_ready;
            @(posedge clock);
            #1;
            if (mem_rd === 1'b1)
            begin
                rd_n++;
                rd_a = mem_addr;
            end
            @(posedge clock);
            // Read data is gone once Q2 has ended
            mem_rdata <= ~rd;
            @(posedge clock);
            #1;
            if (mem_wr === 1'b1)
            begin
                wr_n++;
                wr_a = mem_addr;
                wr_v = mem_wdata;
            end
            @(posedge clock);
        end
        instr_valid <= 1'b0;
        #1;
    endtask : run

    task automatic t_reset;
        chk("phase", 4'b0001, phase);
        chk("working", 8'h00, working_reg);
        chk("bank", 8'h00, bank_select_reg);
        chk("status", 8'h00, status_flags);
        chk("stack_top", 21'h000000, return_stack_top);
    endtask : t_reset

    task automatic t_literals;
        run(16'h0E5A, 16'h0000, 1, 8'h00, 21'h000100);
        chk("working", 8'h5A, working_reg);
        chk("status", 8'h00, status_flags);
        chk("writes", 0, wr_n);
        chk("ready", 1'b1, rdy);
        run(16'h0105, 16'h0000, 1, 8'h00, 21'h000102);
        chk("bank", 8'h05, bank_select_reg);
    endtask : t_literals

    task automatic t_store;
        run(16'h6FFF, 16'h0000, 1, 8'h00, 21'h000104);
        chk("writes", 1, wr_n);
        chk("store_addr", 12'h5FF, wr_a);
        chk("store_data", 8'h5A, wr_v);
        run(16'h6E7F, 16'h0000, 1, 8'h00, 21'h000106);
        chk("store_addr", 12'h07F, wr_a);
        run(16'h6E80, 16'h0000, 1, 8'h00, 21'h000108);
        chk("store_addr", 12'hF80, wr_a);
    endtask : t_store

    task automatic t_negate;
        logic [7:0] tbl [3][3] = '{'{8'h3A, 8'hC6, 8'h10}, '{8'h00, 8'h00, 8'h07},
                                   '{8'h80, 8'h80, 8'h1A}};
        for (int i = 0; i < 3; i++)
        begin
            run(16'h6D10, 16'h0000, 1, tbl[i][0], 21'h00010A);
            chk("neg_read_addr", 12'h510, rd_a);
            chk("neg_addr", 12'h510, wr_a);
            chk("neg_data", tbl[i][1], wr_v);
            chk("status", tbl[i][2], status_flags);
        end
    endtask : t_negate

    task automatic t_mult;
        run(16'h0EE2, 16'h0000, 1, 8'h00, 21'h000110);
        run(16'h0DC4, 16'h0000, 1, 8'h00, 21'h000112);
        chk("prod_high", 8'hAD, product_high_byte);
        chk("prod_low", 8'h08, product_low_byte);
        chk("working", 8'hE2, working_reg);
        chk("status", 8'h1A, status_flags);
        run(16'h0EC4, 16'h0000, 1, 8'h00, 21'h000114);
        run(16'h0322, 16'h0000, 1, 8'hB5, 21'h000116);
        chk("mul_read_addr", 12'h522, rd_a);
        chk("prod_high", 8'h8A, product_high_byte);
        chk("prod_low", 8'h94, product_low_byte);
        chk("writes", 0, wr_n);
        run(16'h0222, 16'h0000, 1, 8'h01, 21'h000118);
        chk("mul_read_addr", 12'h022, rd_a);
        run(16'h0D00, 16'h0000, 1, 8'h00, 21'h00011A);
        chk("prod_low", 8'h00, product_low_byte);
        chk("status", 8'h1A, status_flags);
    endtask : t_mult

    task automatic t_copy;
        run(16'hCABC, 16'hF123, 2, 8'h77, 21'h000120);
        chk("copy_ready", 1'b0, rdy);
        chk("copy_reads", 1, rd_n);
        chk("copy_src", 12'hABC, rd_a);
        chk("copy_writes", 1, wr_n);
        chk("copy_dst", 12'h123, wr_a);
        chk("copy_data", 8'h77, wr_v);
        chk("status", 8'h1A, status_flags);
        run(16'hCFFF, 16'hF000, 2, 8'hA5, 21'h000124);
        chk("copy_src", 12'hFFF, rd_a);
        chk("copy_dst", 12'h000, wr_a);
        chk("copy_data", 8'hA5, wr_v);
    endtask : t_copy

    task automatic wr_tos(input logic [2:0] sel, input logic [7:0] d);
        @(posedge clock);
        tos_wdata <= d;
        {tos_wr_upper, tos_wr_high, tos_wr_low} <= sel;
        @(posedge clock);
        {tos_wr_upper, tos_wr_high, tos_wr_low} <= 3'b000;
    endtask : wr_tos

    task automatic t_stack;
        run(16'h0005, 16'h0000, 1, 8'h00, 21'h001000);
        chk("stack_top", 21'h001002, return_stack_top);
        run(16'h0005, 16'h0000, 1, 8'h00, 21'h0ABCDE);
        chk("stack_top", 21'h0ABCE0, return_stack_top);
        chk("stack_next", 21'h001002, return_stack_next);
        run(16'h0006, 16'h0000, 1, 8'h00, 21'h0ABCE0);
        chk("stack_top", 21'h001002, return_stack_top);
        chk("stack_next", 21'h000000, return_stack_next);
        wr_tos(3'b100, 8'hF5);
        wr_tos(3'b010, 8'h66);
        wr_tos(3'b001, 8'h88);
        #1;
        chk("stack_top", 21'h156688, return_stack_top);
        run(16'h0005, 16'h0000, 1, 8'h00, 21'h000200);
        chk("stack_top", 21'h000202, return_stack_top);
        chk("stack_next", 21'h156688, return_stack_next);
    endtask : t_stack

    task automatic t_idle;
        logic [3:0] p;
        @(posedge clock);
        clock_en <= 1'b0;
        #1;
        p = phase;
        repeat (4) @(posedge clock);
        #1;
        chk("frozen_phase", p, phase);
        @(posedge clock);
        clock_en <= 1'b1;
        // Unlisted opcode must leave every result alone
        run(16'h0004, 16'h0000, 1, 8'h00, 21'h000204);
        chk("working", 8'hC4, working_reg);
        chk("prod_high", 8'h00, product_high_byte);
        chk("writes", 0, wr_n);
    endtask : t_idle

    initial
    begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        #1;
        t_reset();
        t_literals();
        t_store();
        t_negate();
        t_mult();
        t_copy();
        t_stack();
        t_idle();
        close_out();
    end
endmodule : move_multiply_stack_instr_exec_tb_top
